// ---- hw/mah_host.sv ----
module mah_host
   import mah_pkg::*;
#(
   parameter int NUM_CH = 4
)
(
   // system
   input wire logic mclk,
   input wire logic sys_rst,
   // user request
   input wire logic start_req,
   input wire logic [SEL_W-1:0] start_chan,
   output logic start_ready,
   // user result stream
   output logic res_valid,
   output mah_word_t res_data,
   output logic [SEL_W-1:0] res_chan,
   input wire logic res_ready,
   output logic timeout_err,
   // converter pins
   output logic chip_sel_n,
   output logic sample_hold_n,
   output logic read_n,
   output logic channel_select_lsb,
   output logic channel_select_msb,
   input wire logic conv_done_n,
   input wire logic [RESULT_W-1:0] result_bus
);
   import mah_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_WAIT = 3'b011,
      ST_READ = 3'b100,
      ST_RELEASE = 3'b101
   } mah_state_e;

   mah_state_e state;
   logic [CNT_W-1:0] step_cnt;
   logic [CNT_W-1:0] rate_cnt;
   logic [CNT_W-1:0] wait_cnt;
   logic [SEL_W-1:0] chan_hold;
   logic done_meta;
   logic done_sync;
   logic [RESULT_W-1:0] bus_meta;
   logic [RESULT_W-1:0] bus_sync;
   mah_buf_if buf_in ();
   mah_buf_if buf_out ();

   function automatic logic [SEL_W-1:0] mask_chan(input logic [SEL_W-1:0] c);
      // two inputs leave the upper select line unused; any other count below four leaves both unused
      if (NUM_CH >= 4)
         mask_chan = c;
      else if (NUM_CH == 2)
         mask_chan = {1'b0, c[0]};
      else
         mask_chan = '0;
   endfunction : mask_chan

   // pins come from another timing world: two flops before use
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         done_meta <= 1'b1;
         done_sync <= 1'b1;
         bus_meta <= '0;
         bus_sync <= '0;
      end
      else
      begin
         done_meta <= conv_done_n;
         done_sync <= done_meta;
         bus_meta <= result_bus;
         bus_sync <= bus_meta;
      end
   end

   // least spacing between starts
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         rate_cnt <= '0;
      else if (state == ST_SAMPLE && step_cnt == '0)
         rate_cnt <= CNT_W'(START_PERIOD_CYC - 1);
      else if (rate_cnt != '0)
         rate_cnt <= rate_cnt - 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         state <= ST_IDLE;
         step_cnt <= '0;
         wait_cnt <= '0;
         chan_hold <= '0;
         chip_sel_n <= 1'b1;
         sample_hold_n <= 1'b1;
         read_n <= 1'b1;
         channel_select_lsb <= 1'b0;
         channel_select_msb <= 1'b0;
         timeout_err <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               // one conversion at a time, spaced
               if (start_req && start_ready)
               begin
                  chan_hold <= mask_chan(start_chan);
                  {channel_select_msb, channel_select_lsb}
                     <= mask_chan(start_chan);
                  chip_sel_n <= 1'b0;
                  step_cnt <= CNT_W'(SETUP_CYC - 1);
                  state <= ST_SETUP;
               end
            end
            ST_SETUP:
            begin
               if (step_cnt == '0)
               begin
                  sample_hold_n <= 1'b0;
                  step_cnt <= CNT_W'(STROBE_CYC - 1);
                  state <= ST_SAMPLE;
               end
               else
                  step_cnt <= step_cnt - 1'b1;
            end
            ST_SAMPLE:
            begin
               // select lines stay put until sample/hold rises again
               if (step_cnt == '0)
               begin
                  sample_hold_n <= 1'b1;
                  chip_sel_n <= 1'b1;
                  // margin covers the two synchroniser flops
                  wait_cnt <= CNT_W'(CONV_MAX_CYC + SETUP_CYC);
                  state <= ST_WAIT;
               end
               else
                  step_cnt <= step_cnt - 1'b1;
            end
            ST_WAIT:
            begin
               if (!done_sync)
               begin
                  chip_sel_n <= 1'b0;
                  read_n <= 1'b0;
                  step_cnt <= CNT_W'(STROBE_CYC - 1);
                  state <= ST_READ;
               end
               else if (wait_cnt == '0)
               begin
                  // converter never answered: flag and give up
                  timeout_err <= 1'b1;
                  state <= ST_IDLE;
               end
               else
                  wait_cnt <= wait_cnt - 1'b1;
            end
            ST_READ:
            begin
               // bus sampled at the last strobe cycle after settling
               if (step_cnt == '0 && buf_in.ready)
               begin
                  read_n <= 1'b1;
                  chip_sel_n <= 1'b1;
                  state <= ST_RELEASE;
               end
               else if (step_cnt != '0)
                  step_cnt <= step_cnt - 1'b1;
            end
            ST_RELEASE:
            begin
               // wait for done to return high before the next start
               if (done_sync)
                  state <= ST_IDLE;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // result words are plain unsigned codes 0..1023, passed unchanged
   assign buf_in.valid = (state == ST_READ) && (step_cnt == '0);
   assign buf_in.data = bus_sync;
   assign buf_in.chan = chan_hold;

   mah_skid_buf u_buf (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .in_side(buf_in.dst),
      .out_side(buf_out.src)
   );

   // output stage register keeps every result output on a flop
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         res_valid <= 1'b0;
         res_data <= CODE_MIN;
         res_chan <= '0;
      end
      else if (!res_valid || res_ready)
      begin
         res_valid <= buf_out.valid;
         res_data <= buf_out.data;
         res_chan <= buf_out.chan;
      end
   end
   assign buf_out.ready = !res_valid || res_ready;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         start_ready <= 1'b0;
      else
         start_ready <= (state == ST_IDLE) && !(start_req && start_ready)
            && (rate_cnt <= CNT_W'(1));
   end

   // cycles since sample/hold was last low, saturating; the strobe itself
   // stays low for several cycles, so spacing is judged from the fall
   logic [CNT_W-1:0] gap_cnt;
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         gap_cnt <= CNT_W'(START_PERIOD_CYC);
      else if (!sample_hold_n)
         gap_cnt <= '0;
      else if (gap_cnt != CNT_W'(START_PERIOD_CYC))
         gap_cnt <= gap_cnt + 1'b1;
   end

   a_read_needs_cs: assert property (@(posedge mclk) disable iff (sys_rst)
      !read_n |-> !chip_sel_n)
      else $error("read strobe without chip select");
   a_sample_needs_cs: assert property (@(posedge mclk) disable iff (sys_rst)
      !sample_hold_n |-> !chip_sel_n)
      else $error("sample strobe without chip select");
   a_chan_held: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(sample_hold_n) |=> $stable(channel_select_lsb)
         && $stable(channel_select_msb))
      else $error("select lines moved at sample edge");
   a_read_after_done: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(read_n) |-> !done_sync)
      else $error("read before conversion done");
   a_start_spacing: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(sample_hold_n)
         |-> gap_cnt >= CNT_W'(START_PERIOD_CYC - STROBE_CYC))
      else $error("starts too close");
   a_chan_width: assert property (@(posedge mclk) disable iff (sys_rst)
      (NUM_CH < 4) |-> !channel_select_msb)
      else $error("unused select line driven");
   a_wait_bound: assert property (@(posedge mclk) disable iff (sys_rst)
      (state == ST_WAIT) |-> wait_cnt <= CNT_W'(CONV_MAX_CYC + SETUP_CYC))
      else $error("conversion wait too long");
   a_read_len: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(read_n) |-> !read_n [*4])
      else $error("read strobe too short");
endmodule : mah_host

// ---- hw/mah_pkg.sv ----
package mah_pkg;
   localparam int RESULT_W = 10;
   localparam int SEL_W = 2;
   localparam int CLK_PERIOD_NS = 8;
   // longest conversion the converter may take
   localparam int CONV_MAX_NS = 900;
   localparam int CONV_MAX_CYC = (CONV_MAX_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   // 800 kHz start rate gives a 1250 ns least start spacing
   localparam int START_PERIOD_NS = 1250;
   localparam int START_PERIOD_CYC = (START_PERIOD_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   // strobe widths and setup around edges, in cycles
   localparam int SETUP_CYC = 2;
   localparam int STROBE_CYC = 4;
   localparam int CNT_W = 12;
   localparam logic [RESULT_W-1:0] CODE_MIN = 10'h000;
   localparam logic [RESULT_W-1:0] CODE_MAX = 10'h3ff;
   typedef logic [RESULT_W-1:0] mah_word_t;
endpackage : mah_pkg

// ---- hw/mah_buf_if.sv ----
interface mah_buf_if;
   import mah_pkg::*;
   logic valid;
   logic ready;
   mah_word_t data;
   logic [SEL_W-1:0] chan;
   modport src (output valid, output data, output chan, input ready);
   modport dst (input valid, input data, input chan, output ready);
endinterface : mah_buf_if

// ---- hw/mah_skid_buf.sv ----
module mah_skid_buf
   import mah_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   mah_buf_if.dst in_side,
   mah_buf_if.src out_side
);
   // two entries: a receiver stall never drops a result
   mah_word_t mem_data [2];
   logic [SEL_W-1:0] mem_chan [2];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic push;
   logic pop;

   assign in_side.ready = (count != 2'd2);
   assign out_side.valid = (count != 2'd0);
   assign out_side.data = mem_data[rd_ptr];
   assign out_side.chan = mem_chan[rd_ptr];
   assign push = in_side.valid && in_side.ready;
   assign pop = out_side.valid && out_side.ready;

   always_ff @(posedge mclk)
   begin
      if (push)
      begin
         mem_data[wr_ptr] <= in_side.data;
         mem_chan[wr_ptr] <= in_side.chan;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'd0;
      end
      else
      begin
         if (push)
            wr_ptr <= ~wr_ptr;
         if (pop)
            rd_ptr <= ~rd_ptr;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

   a_count_bound: assert property (@(posedge mclk) disable iff (sys_rst)
      count <= 2'd2)
      else $error("buffer count above two");
   a_full_no_ready: assert property (@(posedge mclk) disable iff (sys_rst)
      (count == 2'd2) |-> !in_side.ready)
      else $error("ready while full");
endmodule : mah_skid_buf

// ---- bench/mah_conv_model.sv ----
module mah_conv_model
   import mah_pkg::*;
(
   // converter pins
   input wire logic chip_sel_n,
   input wire logic sample_hold_n,
   input wire logic read_n,
   input wire logic channel_select_lsb,
   input wire logic channel_select_msb,
   output logic conv_done_n,
   output logic [RESULT_W-1:0] result_bus,
   // bench controls
   input wire logic [4*RESULT_W-1:0] codes,
   input wire logic slow,
   input wire logic mute,
   output int viol
);
   timeunit 1ns;
   timeprecision 1ps;
   mah_word_t held;
   logic busy;
   logic rd_en;
   realtime t_start;
   // no clock reaches the converter: it times itself
   initial
   begin
      conv_done_n = 1'b1;
      held = '0;
      busy = 1'b0;
      viol = 0;
      t_start = -2000.0;
   end
   assign rd_en = !read_n && !chip_sel_n;
   // released lines show the inverse, never a stale value
   assign result_bus = rd_en ? held : ~held;
   always @(negedge sample_hold_n)
      if (!chip_sel_n)
      begin
         if (busy || !conv_done_n || $realtime - t_start < 1250.0)
            viol++;
         t_start = $realtime;
         busy = 1'b1;
         fork
            convert({channel_select_msb, channel_select_lsb});
         join_none
      end
   task automatic convert(input logic [1:0] ch);
      mah_word_t code;
      code = mah_word_t'(codes >> (ch * RESULT_W));
      #((slow ? 900 : 600) / 2);
      held = {code[9:5], 5'h00};
      #((slow ? 900 : 600) / 2);
      held[4:0] = code[4:0];
      busy = 1'b0;
      if (!mute)
         conv_done_n = 1'b0;
   endtask : convert
   always @(negedge rd_en)
      conv_done_n = 1'b1;
endmodule : mah_conv_model

// ---- bench/mah_host_tb_top.sv ----
module mah_host_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import mah_pkg::*;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic start_req = 1'b0;
   logic [1:0] start_chan = 2'h0;
   logic res_ready = 1'b0;
   logic start_ready, res_valid, timeout_err;
   mah_word_t res_data;
   logic [1:0] res_chan;
   logic cs_n, sh_n, rd_n, sel0, sel1, done_n;
   logic [RESULT_W-1:0] bus;
   logic [4*RESULT_W-1:0] codes = '0;
   logic slow = 1'b0;
   logic mute = 1'b0;
   logic hold_off = 1'b0;
   int viol, mismatches = 0, total_checks = 0, cyc = 0, i, n;
   logic [31:0] seed = 32'h00013a93;
   logic [31:0] rs = 32'h00013a93;
   logic [11:0] exp_q[$];
   mah_host #(.NUM_CH(4)) i_mah_host (.mclk(mclk), .sys_rst(sys_rst),
      .start_req(start_req), .start_chan(start_chan),
      .start_ready(start_ready), .res_valid(res_valid),
      .res_data(res_data), .res_chan(res_chan), .res_ready(res_ready),
      .timeout_err(timeout_err), .chip_sel_n(cs_n), .sample_hold_n(sh_n),
      .read_n(rd_n), .channel_select_lsb(sel0), .channel_select_msb(sel1),
      .conv_done_n(done_n), .result_bus(bus));
   mah_conv_model i_mah_conv_model (.chip_sel_n(cs_n),
      .sample_hold_n(sh_n), .read_n(rd_n), .channel_select_lsb(sel0),
      .channel_select_msb(sel1), .conv_done_n(done_n), .result_bus(bus),
      .codes(codes), .slow(slow), .mute(mute), .viol(viol));
   always #4 mclk = ~mclk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic check(input string what, input logic [11:0] seen,
      input logic [11:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   // entered at 1 ns after an edge; request held until the taking edge
   task automatic start(input logic [1:0] ch, input mah_word_t code,
      input logic push);
      int k;
      codes[ch*RESULT_W +: RESULT_W] = code;
      start_chan = ch;
      start_req = 1'b1;
      k = 0;
      do
         @(posedge mclk);
      while (start_ready !== 1'b1 && ++k < 400);
      if (start_ready !== 1'b1)
         mismatches++;
      if (push)
         exp_q.push_back({ch, code});
      #1 start_req = 1'b0;
      // the input value must stand until the converter has sampled it
      repeat (SETUP_CYC + 1) @(posedge mclk);
      #1;
   endtask : start
   task automatic drain;
      n = 0;
      while (exp_q.size() != 0 && n++ < 2000)
         @(posedge mclk);
      if (exp_q.size() != 0)
         mismatches++;
      #1;
   endtask : drain
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end
   // receiver stalls at random, or wholly while hold_off is set
   always @(posedge mclk)
   begin
      #1;
      rs = xs(rs);
      res_ready = !hold_off && rs[2:0] != 3'h0;
   end
   always @(posedge mclk)
      if (!sys_rst && res_valid === 1'b1 && res_ready === 1'b1)
         check("result", {res_chan, res_data},
            exp_q.size() != 0 ? exp_q.pop_front() : 12'hfff);
   initial
   begin
      repeat (10) @(posedge mclk);
      #1;
      check("idle pins", {9'h0, cs_n, sh_n, rd_n}, 12'h007);
      sys_rst = 1'b0;
      for (i = 0; i < 4; i++)
         start(i[1:0], i[0] ? CODE_MAX : CODE_MIN, 1'b1);
      for (i = 0; i < 12; i++)
      begin
         seed = xs(seed);
         slow = seed[3];
         start(seed[1:0], seed[13:4], 1'b1);
      end
      drain();
      // two buffer entries plus output register, then the read stalls
      hold_off = 1'b1;
      for (i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         start(seed[1:0], seed[13:4], 1'b1);
      end
      repeat (300) @(posedge mclk);
      #1 hold_off = 1'b0;
      drain();
      mute = 1'b1;
      start(2'h1, 10'h155, 1'b0);
      n = 0;
      while (timeout_err !== 1'b1 && n++ < 400)
         @(posedge mclk);
      #1;
      check("timeout", {11'h0, timeout_err}, 12'h001);
      mute = 1'b0;
      sys_rst = 1'b1;
      // reset clears the host's rate counter: hold it past one start period
      repeat (START_PERIOD_CYC) @(posedge mclk);
      #1 sys_rst = 1'b0;
      check("timeout clr", {11'h0, timeout_err}, 12'h000);
      start(2'h3, 10'h2aa, 1'b1);
      drain();
      check("spacing", viol[11:0], 12'h000);
      tally_and_finish();
   end
endmodule : mah_host_tb_top
